//--- core/driver_fault_protection_manager.sv
// fault detection and response for the integrated three-phase bridge driver
//
// Notes on behaviour
// RL1 - supply undervoltage: all off, device held reset
// RL2 - analog rail low: all off, device reset
// RL3 - buck rail low: buck switches off, reset
// RL4 - pump low: fets off, alert, sticky flag
// RL5 - supply high: fets off, alert, sticky flag
// RL6 - guard bit zero ignores supply high
// RL7 - level pick selects 22 V or 34 V
// RL8 - overcurrent needs filter time, policy selects response
// RL9 - policy 00: latched off until clear
// RL10 - policy 01: retry, summary clears, flags stick
// RL11 - policy 10: report only, clear needed
// RL12 - policy 11: overcurrent fully ignored
// RL13 - buck overcurrent: buck off, device reset
// RL14 - current cap needs filter time, policy field
// RL15 - cap 00xx: chosen bridge state, latched
// RL16 - cap 01xx: chosen state, retry clears flags
// RL17 - cap 1000: report only, clear needed
// RL18 - cap 1xx1: cap event ignored
// RL19 - host must react in report modes
// RL20 - clear pulse only clears absent conditions
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fault_consts.svh"

module driver_fault_protection_manager #(
	parameter int unsigned RETRY_UNIT_CYC = `RETRY_UNIT_CYC,
	parameter int unsigned FILT_UNIT_CYC  = `FILT_UNIT_CYC
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              srst,
	// register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// comparator inputs, asynchronous
	input  wire logic              supply_low_in,
	input  wire logic              analog_rail_low,
	input  wire logic              buck_rail_low,
	input  wire logic              pump_rail_low,
	input  wire logic              supply_over_lo_in,
	input  wire logic              supply_over_hi_in,
	input  wire logic [5:0]        switch_over_in,
	input  wire logic              buck_over_in,
	input  wire logic              sense_over_cap_in,
	// power stage control
	output fault_pkg::bridge_e     bridge_state,
	output logic                   pump_enable,
	output logic                   buck_switch_enable,
	output logic                   core_reset,
	output logic [2:0]             switch_overcurrent_level,
	output logic [3:0]             stall_cap_level,
	// open-drain alert pin
	output logic                   fault_alert_pin_out,
	output logic                   fault_alert_pin_oe
);
	import fault_pkg::*;

	localparam int NCH = 8;
	localparam int CH_CAP = 6;
	localparam int CH_BUCK = 7;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [13:0] raw_in;
	logic [13:0] meta_reg;
	logic [13:0] sync_reg;

	assign raw_in = {sense_over_cap_in, buck_over_in, switch_over_in, supply_over_hi_in,
		supply_over_lo_in, pump_rail_low, buck_rail_low, analog_rail_low, supply_low_in};

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_reg <= 14'h0;
			sync_reg <= 14'h0;
		end else begin
			meta_reg <= raw_in;
			sync_reg <= meta_reg;
		end
	end

	logic supply_s, analog_s, buck_s, pump_s, over_lo_s, over_hi_s;
	logic [NCH-1:0] over_s;
	assign supply_s = sync_reg[0];
	assign analog_s = sync_reg[1];
	assign buck_s = sync_reg[2];
	assign pump_s = sync_reg[3];
	assign over_lo_s = sync_reg[4];
	assign over_hi_s = sync_reg[5];
	assign over_s = {sync_reg[12], sync_reg[13], sync_reg[11:6]};

	// ****************************************
	// configuration and command
	// ****************************************
	logic        dev_rst;
	logic [31:0] cfg_reg;
	logic        clr;
	oc_policy_e  oc_pol;
	cap_policy_t cap_pol;

	// device-level reset: configuration, every filter but the buck one, and the response and flag registers
	assign dev_rst = srst | core_reset;
	assign clr = reg_wr && (reg_addr == `REG_CMD_OFS) && reg_wdata[`CMD_CLEAR_BIT];
	assign oc_pol = oc_policy_e'(cfg_reg[`CFG_OCPOL_LSB +: 2]);
	assign cap_pol = cfg_reg[`CFG_CAPPOL_LSB +: 4];

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			cfg_reg <= `CFG_RESET;
		end else if (reg_wr && reg_addr == `REG_CFG_OFS) begin
			cfg_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			switch_overcurrent_level <= 3'h0;
			stall_cap_level <= 4'h0;
		end else begin
			switch_overcurrent_level <= cfg_reg[`CFG_OCLVL_LSB +: 3];
			stall_cap_level <= cfg_reg[`CFG_CAPLVL_LSB +: 4];
		end
	end

	// ****************************************
	// deglitch filters, one per switch, buck and current cap overcurrent comparator
	// ****************************************
	logic [11:0] oc_lim, cap_lim;
	logic [NCH-1:0] hit, hit_d_reg, ev;

	assign oc_lim = 12'((32'(cfg_reg[`CFG_OCFILT_LSB +: 4]) + 1) * FILT_UNIT_CYC);
	assign cap_lim = 12'((32'(cfg_reg[`CFG_CAPFILT_LSB +: 4]) + 1) * FILT_UNIT_CYC);

	generate
		for (genvar i = 0; i < NCH; i++) begin : g_filt
			logic [11:0] cnt_reg;
			logic [11:0] lim;
			logic        rst_i;
			assign lim = (i == CH_CAP) ? cap_lim : oc_lim;
			// the buck filter must survive the reset it causes
			assign rst_i = (i == CH_BUCK) ? srst : dev_rst;
			assign hit[i] = over_s[i] && (cnt_reg >= lim); // RL8 RL13 RL14
			assign ev[i] = hit[i] && !hit_d_reg[i];
			always_ff @(posedge mclk) begin
				if (rst_i) begin
					cnt_reg <= 12'h0;
					hit_d_reg[i] <= 1'b0;
				end else begin
					hit_d_reg[i] <= hit[i];
					if (!over_s[i])
						cnt_reg <= 12'h0;
					else if (cnt_reg < lim)
						cnt_reg <= cnt_reg + 12'h1;
				end
			end
		end
	endgenerate

	// ****************************************
	// conditions
	// ****************************************
	logic hold_next, ov_cond, oc_cond, oc_ev, cap_cond, cap_ev;

	assign hold_next = supply_s | analog_s | buck_s | hit[CH_BUCK]; // RL1 RL2 RL3 RL13
	assign ov_cond = cfg_reg[`CFG_GUARD_BIT] // RL6
		&& (cfg_reg[`CFG_PICK_BIT] ? over_hi_s : over_lo_s); // RL7
	assign oc_cond = |hit[5:0];
	assign oc_ev = |ev[5:0];
	assign cap_cond = hit[CH_CAP];
	assign cap_ev = ev[CH_CAP];

	// ****************************************
	// switch overcurrent response
	// ****************************************
	logic        oc_shut_reg, oc_retry_reg, oc_rep, oc_expire;
	logic [23:0] oc_cnt_reg;
	logic        sw_oc_flag_reg;
	logic [5:0]  fet_flag_reg;

	assign oc_rep = oc_ev && oc_pol != OC_OFF; // RL12
	assign oc_expire = oc_retry_reg && oc_cnt_reg == 24'h1 && !(oc_ev && oc_pol == OC_RETRY);

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			oc_shut_reg <= 1'b0;
			oc_retry_reg <= 1'b0;
			oc_cnt_reg <= 24'h0;
		end else begin
			oc_shut_reg <= (oc_ev && oc_pol == OC_LATCH) | (oc_shut_reg & ~(clr & ~oc_cond)); // RL9 RL20
			if (oc_ev && oc_pol == OC_RETRY) begin // RL10
				oc_retry_reg <= 1'b1;
				oc_cnt_reg <= 24'((32'(cfg_reg[`CFG_OCRETRY_LSB +: 4]) + 1) * RETRY_UNIT_CYC);
			end else if (oc_retry_reg) begin
				oc_cnt_reg <= oc_cnt_reg - 24'h1;
				if (oc_cnt_reg == 24'h1)
					oc_retry_reg <= 1'b0;
			end
		end
	end

	// flags: a new event wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			sw_oc_flag_reg <= 1'b0;
			fet_flag_reg <= 6'h0;
		end else begin
			sw_oc_flag_reg <= oc_rep | (sw_oc_flag_reg & ~(clr & ~oc_cond)); // RL11 RL20
			fet_flag_reg <= (ev[5:0] & {6{oc_pol != OC_OFF}})
				| (fet_flag_reg & ~({6{clr}} & ~hit[5:0]));
		end
	end

	// ****************************************
	// supply and pump flags
	// ****************************************
	logic pump_flag_reg, supply_flag_reg, power_sum_reg;

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			pump_flag_reg <= 1'b0;
			supply_flag_reg <= 1'b0;
			power_sum_reg <= 1'b0;
		end else begin
			pump_flag_reg <= pump_s | (pump_flag_reg & ~clr); // RL4
			supply_flag_reg <= ov_cond | (supply_flag_reg & ~clr); // RL5
			power_sum_reg <= pump_s | ov_cond | oc_rep
				| (power_sum_reg & ~(oc_expire | (clr & ~oc_cond))); // RL10
		end
	end

	// ****************************************
	// stall current cap response
	// ****************************************
	logic        cap_shut_reg, cap_retry_reg, cap_rep, cap_expire, cap_flag_reg;
	logic [1:0]  cap_act_reg;
	logic [23:0] cap_cnt_reg;

	// other 1xx0 codes besides 1000 are treated as report only
	assign cap_rep = cap_ev && !(cap_pol[3] && cap_pol[0]); // RL18
	assign cap_expire = cap_retry_reg && cap_cnt_reg == 24'h1
		&& !(cap_ev && cap_pol[3:2] == 2'b01);

	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			cap_shut_reg <= 1'b0;
			cap_retry_reg <= 1'b0;
			cap_cnt_reg <= 24'h0;
			cap_act_reg <= 2'h0;
		end else begin
			cap_shut_reg <= (cap_ev && cap_pol[3:2] == 2'b00)
				| (cap_shut_reg & ~(clr & ~cap_cond)); // RL15
			if (cap_ev && !cap_pol[3])
				cap_act_reg <= cap_pol[1:0];
			if (cap_ev && cap_pol[3:2] == 2'b01) begin // RL16
				cap_retry_reg <= 1'b1;
				cap_cnt_reg <= 24'((32'(cfg_reg[`CFG_STRETRY_LSB +: 4]) + 1) * RETRY_UNIT_CYC);
			end else if (cap_retry_reg) begin
				cap_cnt_reg <= cap_cnt_reg - 24'h1;
				if (cap_cnt_reg == 24'h1)
					cap_retry_reg <= 1'b0;
			end
		end
	end

	// one bit carries both the control summary and the cap flag
	always_ff @(posedge mclk) begin
		if (dev_rst) begin
			cap_flag_reg <= 1'b0;
		end else begin
			cap_flag_reg <= cap_rep | (cap_flag_reg & ~(cap_expire | (clr & ~cap_cond))); // RL17
		end
	end

	// ****************************************
	// power stage and alert outputs
	// ****************************************
	logic    stage_off;
	bridge_e bridge_next;

	assign stage_off = hold_next | pump_s | ov_cond | oc_shut_reg | oc_retry_reg;

	always_comb begin
		bridge_next = BR_NORMAL;
		if (stage_off) begin
			bridge_next = BR_ALL_OFF; // RL4 RL5 RL9
		end else if (cap_shut_reg || cap_retry_reg) begin
			case (cap_act_reg)
				2'h0: bridge_next = BR_ALL_OFF;
				2'h1: bridge_next = BR_RECIRC;
				2'h2: bridge_next = BR_HIGH_ON;
				2'h3: bridge_next = BR_LOW_ON;
				default: bridge_next = BR_ALL_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			bridge_state <= BR_NORMAL;
			core_reset <= 1'b0;
			pump_enable <= 1'b1;
			buck_switch_enable <= 1'b1;
		end else begin
			bridge_state <= bridge_next;
			core_reset <= hold_next; // RL1 RL2 RL3 RL13
			pump_enable <= !hold_next;
			buck_switch_enable <= !(buck_s | hit[CH_BUCK]);
		end
	end

	// report-only modes leave the pin released; the host polls status
	always_ff @(posedge mclk) begin
		if (srst) begin
			fault_alert_pin_out <= 1'b0;
			fault_alert_pin_oe <= 1'b0;
		end else begin
			fault_alert_pin_out <= 1'b0;
			fault_alert_pin_oe <= !hold_next && (pump_s | ov_cond | oc_shut_reg
				| oc_retry_reg | cap_shut_reg | cap_retry_reg);
		end
	end

	// ****************************************
	// register read port
	// ****************************************
	logic [31:0] status_word;

	assign status_word = {20'h0, fet_flag_reg, cap_flag_reg, sw_oc_flag_reg, supply_flag_reg,
		pump_flag_reg, cap_flag_reg, power_sum_reg};

	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_CFG_OFS:  reg_rdata <= cfg_reg;
				`REG_STAT_OFS: reg_rdata <= status_word;
				default:       reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	a_uvlo_hold: assert property (@(posedge mclk) disable iff (srst) // RL1
		supply_s |=> core_reset && !pump_enable && bridge_state == BR_ALL_OFF)
		else $error("supply undervoltage did not hold the device");
	a_analog_hold: assert property (@(posedge mclk) disable iff (srst) // RL2
		analog_s |=> core_reset && !pump_enable)
		else $error("analog rail low did not hold the device");
	a_buck_off: assert property (@(posedge mclk) disable iff (srst) // RL3
		(buck_s || hit[CH_BUCK]) |=> !buck_switch_enable && core_reset)
		else $error("buck fault left the buck switching");
	a_pump_alert: assert property (@(posedge mclk) disable iff (dev_rst) // RL4
		pump_s && !hold_next |=> pump_flag_reg && fault_alert_pin_oe
		&& bridge_state == BR_ALL_OFF)
		else $error("pump low not reported");
	a_guard_off: assert property (@(posedge mclk) disable iff (dev_rst) // RL6
		!cfg_reg[`CFG_GUARD_BIT] && !supply_flag_reg |=> !supply_flag_reg)
		else $error("supply high flagged with guard off");
	a_level_low: assert property (@(posedge mclk) disable iff (dev_rst) // RL7
		cfg_reg[`CFG_GUARD_BIT] && !cfg_reg[`CFG_PICK_BIT] && over_lo_s |=> supply_flag_reg)
		else $error("low supply-high level ignored");
	a_oc_latched: assert property (@(posedge mclk) disable iff (dev_rst) // RL9
		oc_ev && oc_pol == OC_LATCH && !hold_next |=> oc_shut_reg
		##1 (bridge_state == BR_ALL_OFF || core_reset))
		else $error("latched overcurrent did not shut the bridge");
	a_oc_ignored: assert property (@(posedge mclk) disable iff (dev_rst) // RL12
		oc_pol == OC_OFF && !sw_oc_flag_reg |=> !sw_oc_flag_reg && !oc_shut_reg)
		else $error("disabled overcurrent reacted");
	a_oc_expire: assert property (@(posedge mclk) disable iff (dev_rst) // RL10
		oc_expire && !pump_s && !ov_cond |=> !oc_retry_reg && !power_sum_reg)
		else $error("retry expiry did not clear summary");
	a_cap_high: assert property (@(posedge mclk) disable iff (dev_rst) // RL15
		cap_shut_reg && cap_act_reg == 2'h2 && !stage_off |=> bridge_state == BR_HIGH_ON)
		else $error("cap latched state not applied");
	a_cap_off: assert property (@(posedge mclk) disable iff (dev_rst) // RL18
		cap_pol[3] && cap_pol[0] && !cap_flag_reg |=> !cap_flag_reg && !cap_shut_reg)
		else $error("disabled cap reacted");
	a_clear_wait: assert property (@(posedge mclk) disable iff (dev_rst) // RL20
		clr && oc_cond && sw_oc_flag_reg |=> sw_oc_flag_reg)
		else $error("clear removed a live overcurrent flag");

	c_oc_retry: cover property (@(posedge mclk) disable iff (dev_rst) oc_expire);
	c_cap_retry: cover property (@(posedge mclk) disable iff (dev_rst) cap_expire);
	c_clear_latched: cover property (@(posedge mclk) disable iff (dev_rst)
		oc_shut_reg && clr && !oc_cond);
	c_device_hold: cover property (@(posedge mclk) disable iff (srst) $rose(core_reset));

endmodule

`default_nettype wire

//--- core/fault_consts.svh
// offsets, field positions, reset values and timing counts of the fault manager
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define REG_CFG_OFS          8'h00
`define REG_STAT_OFS         8'h04
`define REG_CMD_OFS          8'h08

// ****************************************
// configuration word fields
// ****************************************
`define CFG_GUARD_BIT        0
`define CFG_PICK_BIT         1
`define CFG_OCPOL_LSB        2
`define CFG_CAPPOL_LSB       4
`define CFG_OCFILT_LSB       8
`define CFG_CAPFILT_LSB      12
`define CFG_OCRETRY_LSB      16
`define CFG_STRETRY_LSB      20
`define CFG_OCLVL_LSB        24
`define CFG_CAPLVL_LSB       28
`define CFG_RESET            32'h0000_0001

// ****************************************
// status word fields
// ****************************************
`define ST_POWER_SUM_BIT     0
`define ST_CTRL_SUM_BIT      1
`define ST_PUMP_BIT          2
`define ST_SUPPLY_BIT        3
`define ST_SWOC_BIT          4
`define ST_CAP_BIT           5
`define ST_FET_LSB           6

// ****************************************
// command word fields
// ****************************************
`define CMD_CLEAR_BIT        0

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS        8
`define FILT_UNIT_NS         1000
`define FILT_UNIT_CYC        ((`FILT_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RETRY_UNIT_US        1000
`define RETRY_UNIT_CYC       ((`RETRY_UNIT_US * 1000) / `CLK_PERIOD_NS)

`endif

//--- core/fault_pkg.sv
// types shared by the fault manager and its bench
package fault_pkg;

	// state applied to the three half bridges
	typedef enum logic [2:0] {
		BR_NORMAL,
		BR_ALL_OFF,
		BR_RECIRC,
		BR_HIGH_ON,
		BR_LOW_ON
	} bridge_e;

	// overcurrent policy codes
	typedef enum logic [1:0] {
		OC_LATCH,
		OC_RETRY,
		OC_REPORT,
		OC_OFF
	} oc_policy_e;

	typedef logic [3:0] cap_policy_t;

endpackage

//--- test/driver_fault_protection_manager_bench.sv
// self-checking bench of the fault manager
`timescale 1ns/1ps
`default_nettype none

module driver_fault_protection_manager_bench;
	import fault_pkg::*;

	// ****************************************
	// pins, tables and counters
	// ****************************************
	logic        mclk, srst, reg_wr, reg_rd, pump_low, cap_in;
	logic        over_lo, over_hi, pump_enable, buck_en, core_reset;
	logic        alert_out, alert_oe, alert_line;
	logic [7:0]  reg_addr, volts;
	logic [31:0] reg_wdata, reg_rdata, rd_word;
	logic [5:0]  sw_over;
	logic [3:0]  rst_src, cap_lvl;
	logic [2:0]  oc_lvl;
	bridge_e     bridge_state;
	int          failures, n_tests;
	logic [31:0] sup_cfg [4] = '{32'h1, 32'h3, 32'h3, 32'h0};
	logic [7:0]  sup_v   [4] = '{8'd25, 8'd25, 8'd40, 8'd40};
	logic        sup_hit [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic [7:0]  oc_stat [4] = '{8'h91, 8'h90, 8'h91, 8'h00};
	bridge_e     cap_map [4] = '{BR_ALL_OFF, BR_RECIRC, BR_HIGH_ON, BR_LOW_ON};

	// short units keep retry and filter waits within a few dozen cycles
	driver_fault_protection_manager #(.RETRY_UNIT_CYC(20), .FILT_UNIT_CYC(2)) dut (
		.mclk                     (mclk),
		.srst                     (srst),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.supply_low_in            (rst_src[0]),
		.analog_rail_low          (rst_src[1]),
		.buck_rail_low            (rst_src[2]),
		.pump_rail_low            (pump_low),
		.supply_over_lo_in        (over_lo),
		.supply_over_hi_in        (over_hi),
		.switch_over_in           (sw_over),
		.buck_over_in             (rst_src[3]),
		.sense_over_cap_in        (cap_in),
		.bridge_state             (bridge_state),
		.pump_enable              (pump_enable),
		.buck_switch_enable       (buck_en),
		.core_reset               (core_reset),
		.switch_overcurrent_level (oc_lvl),
		.stall_cap_level          (cap_lvl),
		.fault_alert_pin_out      (alert_out),
		.fault_alert_pin_oe       (alert_oe)
	);

	fault_plant plant (
		.volts      (volts),
		.alert_out  (alert_out),
		.alert_oe   (alert_oe),
		.over_lo    (over_lo),
		.over_hi    (over_hi),
		.alert_line (alert_line)
	);

	// ****************************************
	// bus tasks and checking
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rd_word = reg_rdata;
	endtask

	// clear only after the condition has gone, so everything must drop
	task automatic clear_idle;
		wr(8'h08, 32'h1);
		wait_cyc(3);
		rd(8'h04);
		chk(rd_word, 32'h0);
		chk(bridge_state, BR_NORMAL);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// clock, watchdog and test sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		#400000;
		failures++;
		give_verdict();
	end

	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		volts = 8'd12;
		pump_low = 1'b0;
		cap_in = 1'b0;
		sw_over = 6'h00;
		rst_src = 4'h0;
		failures = 0;
		n_tests = 0;
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		wait_cyc(2);
		rd(8'h00);
		chk(rd_word, 32'h1);
		rd(8'h0c);
		chk(rd_word, 32'h0);
		chk(alert_line, 1'b1);
		wr(8'h00, 32'ha500_0001);
		wait_cyc(3);
		chk(oc_lvl, 3'h5);
		chk(cap_lvl, 4'ha);
		// pump low: auto resume, sticky flag survives a clear while present
		@(posedge mclk);
		pump_low <= 1'b1;
		wait_cyc(5);
		chk(bridge_state, BR_ALL_OFF);
		chk(alert_line, 1'b0);
		rd(8'h04);
		chk(rd_word, 32'h5);
		wr(8'h08, 32'h1);
		rd(8'h04);
		chk(rd_word[2], 1'b1);
		@(posedge mclk);
		pump_low <= 1'b0;
		wait_cyc(5);
		chk(bridge_state, BR_NORMAL);
		chk(alert_line, 1'b1);
		rd(8'h04);
		chk(rd_word[2], 1'b1);
		clear_idle();
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, sup_cfg[i]);
			@(posedge mclk);
			volts <= sup_v[i];
			wait_cyc(5);
			chk(bridge_state, sup_hit[i] ? BR_ALL_OFF : BR_NORMAL);
			chk(alert_line, !sup_hit[i]);
			rd(8'h04);
			chk(rd_word, sup_hit[i] ? 32'h9 : 32'h0);
			@(posedge mclk);
			volts <= 8'd12;
			wait_cyc(5);
			chk(bridge_state, BR_NORMAL);
			clear_idle();
		end
		for (int p = 0; p < 4; p++) begin
			wr(8'h00, 32'h1 | (p << 2));
			@(posedge mclk);
			sw_over <= 6'h02;
			@(posedge mclk);
			@(posedge mclk);
			sw_over <= 6'h00;
			wait_cyc(8);
			rd(8'h04);
			chk(rd_word, 32'h0);
			@(posedge mclk);
			sw_over <= 6'h02;
			wait_cyc(8);
			chk(bridge_state, p < 2 ? BR_ALL_OFF : BR_NORMAL);
			chk(alert_line, p > 1);
			wr(8'h08, 32'h1);
			@(posedge mclk);
			sw_over <= 6'h00;
			wait_cyc(40);
			chk(bridge_state, p == 0 ? BR_ALL_OFF : BR_NORMAL);
			rd(8'h04);
			chk(rd_word, oc_stat[p]);
			clear_idle();
		end
		for (int c = 0; c < 16; c++) begin
			wr(8'h00, 32'h1 | (c << 4));
			@(posedge mclk);
			cap_in <= 1'b1;
			wait_cyc(8);
			chk(bridge_state, c > 7 ? BR_NORMAL : cap_map[c % 4]);
			chk(alert_line, c > 7);
			rd(8'h04);
			chk(rd_word, (c[3] & c[0]) ? 32'h0 : 32'h22);
			@(posedge mclk);
			cap_in <= 1'b0;
			wait_cyc(40);
			chk(bridge_state, c < 4 ? cap_map[c % 4] : BR_NORMAL);
			rd(8'h04);
			chk(rd_word, (c < 4 || (c > 7 && !c[0])) ? 32'h22 : 32'h0);
			clear_idle();
		end
		// reset sources: cfg returns to its reset word, writes while held are lost
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, 32'h3);
			@(posedge mclk);
			rst_src <= 4'(1 << i);
			wait_cyc(8);
			chk(core_reset, 1'b1);
			chk(i > 1 || bridge_state === BR_ALL_OFF, 1'b1);
			chk(i > 1 || pump_enable === 1'b0, 1'b1);
			chk(i < 2 || buck_en === 1'b0, 1'b1);
			wr(8'h00, 32'h3);
			@(posedge mclk);
			rst_src <= 4'h0;
			wait_cyc(10);
			chk(core_reset, 1'b0);
			rd(8'h00);
			chk(rd_word, 32'h1);
		end
		give_verdict();
	end
endmodule

`default_nettype wire

//--- test/fault_plant.sv
// comparator and pull-up model of the power side facing the fault manager
`timescale 1ns/1ps
`default_nettype none

module fault_plant (
	// supply level in whole volts
	input  wire logic [7:0] volts,
	// alert pin as the fault manager drives it
	input  wire logic       alert_out,
	input  wire logic       alert_oe,
	// comparator outputs and the pulled-up wire
	output logic            over_lo,
	output logic            over_hi,
	output logic            alert_line
);
	// ****************************************
	// supply comparators, no hysteresis modelled
	// ****************************************
	assign over_lo = volts > 8'd22;
	assign over_hi = volts > 8'd34;

	// ****************************************
	// open-drain wire, pull-up wins when released
	// ****************************************
	assign alert_line = alert_oe ? alert_out : 1'b1;
endmodule

`default_nettype wire
